// ===== rtl/ext_mem_alu.sv
// extended data-memory ALU: add, and, clear operations on any address
// assumes a synchronous data memory with one-cycle read latency
`timescale 1ns/10ps
module ext_mem_alu (
  input  wire logic                            clk_i,       // core clock
  input  wire logic                            nrst_i,      // async reset
  input  wire logic                            req_i,       // op request
  input  wire ext_alu_pkg::op_t                op_i,        // operation
  input  wire logic [ext_alu_pkg::ADDR_W-1:0]  addr_i,      // full address
  input  wire logic [ext_alu_pkg::BIT_W-1:0]   bit_sel_i,   // bit index
  output logic                                 busy_o,      // op running
  output logic                                 done_o,      // op finished
  output logic                                 mem_rd_o,    // mem read
  output logic                                 mem_wr_o,    // mem write
  output logic [ext_alu_pkg::ADDR_W-1:0]       mem_addr_o,  // mem address
  output logic [ext_alu_pkg::DATA_W-1:0]       mem_wdata_o, // write data
  input  wire logic [ext_alu_pkg::DATA_W-1:0]  mem_rdata_i, // read data
  output logic [ext_alu_pkg::DATA_W-1:0]       acc_o,       // accumulator
  output logic                                 carry_o,     // carry flag
  output logic                                 nibble_carry_flag_o, // half cy
  output logic                                 zero_o,      // zero flag
  output logic                                 signed_range_flag_o, // overflow
  output logic                                 signed_overflow_bit_o // sign
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ext_alu_pkg::state_t                  st_q, st_d;
  ext_alu_pkg::op_t                     op_q, op_d;
  logic [ext_alu_pkg::ADDR_W-1:0]       addr_q, addr_d;
  logic [ext_alu_pkg::BIT_W-1:0]        bit_q, bit_d;
  logic [ext_alu_pkg::DATA_W-1:0]       acc_q, acc_d;
  logic [ext_alu_pkg::DATA_W-1:0]       wdata_q, wdata_d;
  logic [ext_alu_pkg::FLG_W-1:0]        flg_q, flg_d;
  logic                                 wr_q, wr_d;
  logic                                 done_q, done_d;

  logic [ext_alu_pkg::DATA_W-1:0]       sum, res;
  logic                                 c_add, ac_add, ov_add, sc_add;
  logic                                 use_cin, to_acc;
  logic                                 take;
  logic [ext_alu_pkg::DATA_W-1:0]       keep_mask;

  // ----------------------------------------------------------------
  // request acceptance
  // ----------------------------------------------------------------
  // a request while busy is dropped without notice
  assign take = req_i && (st_q == ext_alu_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  always_comb begin
    use_cin = 1'b0;
    to_acc  = 1'b0;
    case (op_q)
      ext_alu_pkg::ext_add_carry_to_acc: begin
        use_cin = 1'b1;
        to_acc  = 1'b1;
      end
      ext_alu_pkg::ext_add_carry_to_mem: begin
        use_cin = 1'b1;
      end
      ext_alu_pkg::ext_sum_to_acc,
      ext_alu_pkg::ext_bitwise_and_to_acc: begin
        to_acc = 1'b1;
      end
      default: begin
        to_acc = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // bit clear mask
  // ----------------------------------------------------------------
  // single zero bit
  for (genvar i = 0; i < ext_alu_pkg::DATA_W; i++) begin : g_keep
    assign keep_mask[i] = (int'(bit_q) != i);
  end

  // ----------------------------------------------------------------
  // adder
  // ----------------------------------------------------------------
  // carry-in only for the add-with-carry ops; the flag fed in is the one before this op

  ext_alu_adder u_add (
    .a_i   (acc_q),
    .b_i   (mem_rdata_i),
    .cin_i (use_cin & flg_q[ext_alu_pkg::FLG_C]),
    .sum_o (sum),
    .c_o   (c_add),
    .ac_o  (ac_add),
    .ov_o  (ov_add),
    .sc_o  (sc_add)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    addr_d  = addr_q;
    bit_d   = bit_q;
    acc_d   = acc_q;
    wdata_d = wdata_q;
    flg_d   = flg_q;
    wr_d    = 1'b0;
    done_d  = 1'b0;
    res     = ext_alu_pkg::ZERO_BYTE;
    case (st_q)
      ext_alu_pkg::ST_IDLE: begin
        if (take) begin
          op_d   = op_i;
          addr_d = addr_i;
          bit_d  = bit_sel_i;
          st_d   = ext_alu_pkg::ST_READ;
        end
      end
      ext_alu_pkg::ST_READ: begin
        st_d = ext_alu_pkg::ST_EXEC;
      end
      ext_alu_pkg::ST_EXEC: begin
        st_d   = ext_alu_pkg::ST_IDLE;
        done_d = 1'b1;
        case (op_q)
          ext_alu_pkg::ext_add_carry_to_acc,
          ext_alu_pkg::ext_add_carry_to_mem,
          ext_alu_pkg::ext_sum_to_acc,
          ext_alu_pkg::ext_sum_to_mem: begin
            res = sum;
            flg_d[ext_alu_pkg::FLG_C]  = c_add;
            flg_d[ext_alu_pkg::FLG_AC] = ac_add;
            flg_d[ext_alu_pkg::FLG_OV] = ov_add;
            flg_d[ext_alu_pkg::FLG_SC] = sc_add;
            flg_d[ext_alu_pkg::FLG_Z]  = (sum == ext_alu_pkg::ZERO_BYTE);
          end
          ext_alu_pkg::ext_bitwise_and_to_acc,
          ext_alu_pkg::ext_bitwise_and_to_mem: begin
            res = acc_q & mem_rdata_i;
            flg_d[ext_alu_pkg::FLG_Z] = (res == ext_alu_pkg::ZERO_BYTE);
          end
          ext_alu_pkg::ext_mem_clear: begin
            res = ext_alu_pkg::ZERO_BYTE;
          end
          ext_alu_pkg::ext_bit_clear: begin
            res = mem_rdata_i & keep_mask;
          end
          default: begin
            res = mem_rdata_i;
          end
        endcase
        if (to_acc) begin
          acc_d = res;
        end else begin
          wr_d    = 1'b1;
          wdata_d = res;
        end
      end
      default: begin
        st_d = ext_alu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q    <= ext_alu_pkg::ST_IDLE;
      op_q    <= ext_alu_pkg::ext_sum_to_acc;
      addr_q  <= '0;
      bit_q   <= '0;
      acc_q   <= ext_alu_pkg::ACC_RST;
      wdata_q <= ext_alu_pkg::ZERO_BYTE;
      flg_q   <= ext_alu_pkg::FLG_RST;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      bit_q   <= bit_d;
      acc_q   <= acc_d;
      wdata_q <= wdata_d;
      flg_q   <= flg_d;
      wr_q    <= wr_d;
      done_q  <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy_o                = (st_q != ext_alu_pkg::ST_IDLE);
  assign done_o                = done_q;
  assign mem_rd_o              = (st_q == ext_alu_pkg::ST_READ);
  assign mem_wr_o              = wr_q;
  assign mem_addr_o            = addr_q;
  assign mem_wdata_o           = wdata_q;
  assign acc_o                 = acc_q;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // flags straight from registers
  assign carry_o               = flg_q[ext_alu_pkg::FLG_C];
  assign nibble_carry_flag_o   = flg_q[ext_alu_pkg::FLG_AC];
  assign zero_o                = flg_q[ext_alu_pkg::FLG_Z];
  assign signed_range_flag_o   = flg_q[ext_alu_pkg::FLG_OV];
  assign signed_overflow_bit_o = flg_q[ext_alu_pkg::FLG_SC];

endmodule

// ===== inc/ext_alu_pkg.sv
// constants and types for the extended data-memory ALU block
// assumes a core decoder that issues one operation per request pulse
//
// Operation
// - operands are reached by a full data-memory address, no bank select.
// - add with carry to acc: acc = acc + mem + c, five flags updated.
// - add with carry to mem: mem = acc + mem + c, five flags updated.
// - add to acc without carry-in, five flags updated.
// - add to mem without carry-in, five flags updated.
// - and to acc: acc = acc & mem, only zero flag changes.
// - and to mem: mem = acc & mem, only zero flag changes.
// - byte clear writes zero to memory, flags unchanged.
// - bit clear zeroes one selected bit, others kept, flags unchanged.
package ext_alu_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int BIT_W  = 3;
  localparam int NIB_W  = 4;

  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // status flag vector positions
  localparam int FLG_C  = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_SC = 4;
  localparam int FLG_W  = 5;
  localparam logic [FLG_W-1:0] FLG_RST = 5'h00;

  typedef enum logic [3:0] {
    ext_add_carry_to_acc   = 4'h0,
    ext_add_carry_to_mem   = 4'h1,
    ext_sum_to_acc         = 4'h2,
    ext_sum_to_mem         = 4'h3,
    ext_bitwise_and_to_acc = 4'h4,
    ext_bitwise_and_to_mem = 4'h5,
    ext_mem_clear          = 4'h6,
    ext_bit_clear          = 4'h7
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_EXEC  = 2'h3
  } state_t;

endpackage

// ===== rtl/ext_alu_adder.sv
// 8-bit adder with nibble carry, carry and signed flags
// assumes purely combinational use by the extended ALU top
`timescale 1ns/10ps
module ext_alu_adder (
  input  wire logic [7:0] a_i,    // accumulator operand
  input  wire logic [7:0] b_i,    // memory operand
  input  wire logic       cin_i,  // carry in
  output logic      [7:0] sum_o,  // sum
  output logic            c_o,    // carry out of bit 7
  output logic            ac_o,   // carry out of bit 3
  output logic            ov_o,   // two's complement overflow
  output logic            sc_o    // signed result sign bit
);

  logic [4:0] lo;
  logic [3:0] hi6;
  logic [1:0] top;

  always_comb begin
    lo    = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    hi6   = {1'b0, a_i[6:4]} + {1'b0, b_i[6:4]} + {3'h0, lo[4]};
    top   = {1'b0, a_i[7]} + {1'b0, b_i[7]} + {1'b0, hi6[3]};
    sum_o = {top[0], hi6[2:0], lo[3:0]};
    c_o   = top[1];
    ac_o  = lo[4];
    ov_o  = top[1] ^ hi6[3];
    sc_o  = top[0] ^ ov_o;
  end

endmodule

// ===== verif/ext_mem_alu_chk.sv
// checker for request timing, write-back and flags of ext_mem_alu
// assumes it is bound onto the ext_mem_alu top module
`timescale 1ns/10ps
module ext_mem_alu_chk (
  input wire logic                          clk_i,
  input wire logic                          nrst_i,
  input wire logic                          req_i,
  input wire ext_alu_pkg::op_t              op_i,
  input wire logic [ext_alu_pkg::ADDR_W-1:0] addr_i,
  input wire logic                          busy_o,
  input wire logic                          done_o,
  input wire logic                          mem_rd_o,
  input wire logic                          mem_wr_o,
  input wire logic [ext_alu_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [ext_alu_pkg::DATA_W-1:0] mem_wdata_o,
  input wire logic [ext_alu_pkg::DATA_W-1:0] mem_rdata_i,
  input wire logic [ext_alu_pkg::DATA_W-1:0] acc_o,
  input wire logic                          carry_o,
  input wire logic                          nibble_carry_flag_o,
  input wire logic                          zero_o,
  input wire logic                          signed_range_flag_o,
  input wire logic                          signed_overflow_bit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [4:0] flg;
  assign flg = {signed_overflow_bit_o, signed_range_flag_o, zero_o,
                nibble_carry_flag_o, carry_o};
  sequence s_take; req_i && !busy_o; endsequence
  sequence s_run; busy_o && mem_rd_o ##1 busy_o && !mem_rd_o; endsequence
  a_done_after:
    assert property (s_take |=> s_run ##1 done_o && !busy_o)
    else $error("done not three cycles after request");
  a_full_addr:
    assert property (s_take |=> mem_addr_o == $past(addr_i))
    else $error("memory address differs from request");
  a_clear_zero:
    assert property ((s_take and op_i == ext_alu_pkg::ext_mem_clear) |->
      ##3 mem_wr_o && mem_wdata_o == 8'h00) else $error("clear not zero");
  a_sum_mem:
    assert property ((s_take and op_i == ext_alu_pkg::ext_sum_to_mem) |-> ##3
      mem_wr_o && mem_wdata_o == $past(acc_o, 3) + $past(mem_rdata_i))
    else $error("memory sum wrong");
  a_and_zero:
    assert property ((s_take and op_i == ext_alu_pkg::ext_bitwise_and_to_acc)
      |-> ##3 zero_o == (acc_o == 8'h00) &&
      flg[4:3] == $past(flg[4:3], 3) && flg[1:0] == $past(flg[1:0], 3))
    else $error("and flags wrong");
  a_clr_flags:
    assert property ((s_take and op_i >= ext_alu_pkg::ext_mem_clear) |->
      ##3 flg == $past(flg, 3)) else $error("clear changed flags");
  a_acc_kept:
    assert property ((s_take and op_i[0]) |-> ##3 acc_o == $past(acc_o, 3))
    else $error("accumulator changed by memory op");
  a_acc_no_wr:
    assert property ((s_take and
      (!op_i[0] && op_i != ext_alu_pkg::ext_mem_clear))
      |-> ##3 !mem_wr_o) else $error("write on accumulator op");
endmodule

// ===== verif/ext_mem_model.sv
// data memory seen by ext_mem_alu, one-cycle read latency
// assumes the bench preloads mem_q directly
`timescale 1ns/10ps
module ext_mem_model (
  input  wire logic       clk_i,   // core clock
  input  wire logic       rd_i,    // read strobe
  input  wire logic       wr_i,    // write strobe
  input  wire logic [8:0] addr_i,  // byte address
  input  wire logic [7:0] wdata_i, // write data
  output logic      [7:0] rdata_o  // read data
);
  logic [7:0] mem_q [512];
  logic [7:0] last_q = 8'h00;
  logic       valid_q = 1'b0;
  always @(posedge clk_i) begin
    if (wr_i) mem_q[addr_i] <= wdata_i;
    valid_q <= rd_i;
    if (rd_i) last_q <= mem_q[addr_i];
  end
  // data only valid one cycle after the read, garbage otherwise
  assign rdata_o = valid_q ? last_q : ~last_q;
endmodule

// ===== verif/tb_extended_mem_alu_ops.sv
// self-checking bench for ext_mem_alu with a data memory model
// assumes ext_alu_pkg is compiled first
`timescale 1ns/10ps
module tb_extended_mem_alu_ops;
  logic clk_i, nrst_i, req_i, busy_o, done_o, mem_rd_o, mem_wr_o;
  logic c, ac, z, ov, sc;
  ext_alu_pkg::op_t op_i;
  logic [8:0] addr_i, mem_addr_o;
  logic [2:0] bit_sel_i;
  logic [7:0] mem_wdata_o, mem_rdata_i, acc_o;
  int n_errors = 0;
  int total_checks = 0;
  ext_mem_alu u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i),
    .op_i(op_i), .addr_i(addr_i), .bit_sel_i(bit_sel_i), .busy_o(busy_o),
    .done_o(done_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .acc_o(acc_o), .carry_o(c),
    .nibble_carry_flag_o(ac), .zero_o(z), .signed_range_flag_o(ov),
    .signed_overflow_bit_o(sc));
  ext_mem_model u_mem (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic test_done();
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one operation; flags given as {sc, ov, z, ac, c}
  task automatic step(input logic [3:0] o, input logic [8:0] a,
      input logic [2:0] b, input logic [7:0] m, ea, em, input logic [4:0] ef);
    int n;
    u_mem.mem_q[a] = m;
    req_i = 1'b1;
    op_i = ext_alu_pkg::op_t'(o);
    addr_i = a;
    bit_sel_i = b;
    @(negedge clk_i);
    req_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    chk({7'h00, done_o}, 8'h01);
    @(negedge clk_i);
    chk(acc_o, ea);
    chk(u_mem.mem_q[a], em);
    chk({3'h0, sc, ov, z, ac, c}, {3'h0, ef});
  endtask
  task automatic t_add();
    step(4'h2, 9'h1A5, 3'h0, 8'h7F, 8'h7F, 8'h7F, 5'h00);
    step(4'h0, 9'h0A0, 3'h0, 8'h81, 8'h00, 8'h81, 5'h07);
    step(4'h2, 9'h1FF, 3'h0, 8'h40, 8'h40, 8'h40, 5'h00);
    step(4'h3, 9'h005, 3'h0, 8'h40, 8'h40, 8'h80, 5'h08);
    step(4'h1, 9'h100, 3'h0, 8'hC0, 8'h40, 8'h00, 5'h05);
  endtask
  task automatic t_and();
    step(4'h4, 9'h0F0, 3'h0, 8'hC3, 8'h40, 8'hC3, 5'h01);
    step(4'h5, 9'h123, 3'h0, 8'h0F, 8'h40, 8'h00, 5'h05);
  endtask
  task automatic t_clear();
    step(4'h6, 9'h0AA, 3'h0, 8'hAA, 8'h40, 8'h00, 5'h05);
    step(4'h7, 9'h150, 3'h7, 8'hFF, 8'h40, 8'h7F, 5'h05);
    step(4'h7, 9'h151, 3'h0, 8'hFF, 8'h40, 8'hFE, 5'h05);
    step(4'h1, 9'h1FE, 3'h0, 8'h01, 8'h40, 8'h42, 5'h00);
  endtask
  initial begin
    nrst_i = 1'b0;
    req_i = 1'b0;
    op_i = ext_alu_pkg::ext_add_carry_to_acc;
    addr_i = 9'h000;
    bit_sel_i = 3'h0;
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    t_add();
    t_and();
    t_clear();
    test_done();
  end
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule
bind ext_mem_alu ext_mem_alu_chk u_chk (.*);
